// File: rtl/qps_serial_front.sv
// Serial front end of a quad 256-step potentiometer: a three-wire
// shift port on its own clock and a two-wire slave oversampled on
// ref_clk_i. Assumes all pins are asynchronous to ref_clk_i and that
// spi_clk_i is the shift port clock, which may stop between frames.
`timescale 1ns/1ns
`include "qps_defines.svh"

module qps_serial_front #(
    parameter logic [4:0] ADDR_PREFIX = 5'h12 // Arbitrary value
) (
    input  wire logic                     ref_clk_i,
    input  wire logic                     rst_n_i,
    input  wire logic                     interface_select_pin_i,
    input  wire logic                     global_shutdown_pin_n_i,
    input  wire logic                     wiper_reset_pin_n_i,
    input  wire logic                     spi_clk_i,
    input  wire logic                     spi_cs_n_i,
    input  wire logic                     spi_sdi_i,
    output logic                          spi_sdo_o,
    output logic                          spi_sdo_oe_o,
    input  wire logic                     scl_i,
    input  wire logic                     sda_i,
    output logic                          sda_o,
    output logic                          sda_oe_o,
    input  wire logic                     bus_address_pin_lo_i,
    input  wire logic                     bus_address_pin_hi_i,
    output logic [3:0][7:0]               wiper_code_latch_o,
    output logic [3:0]                    channel_off_o,
    output logic                          logic_output_one_o,
    output logic                          logic_output_two_o
);

    // ==============================================================
    // Declarations
    logic [9:0]            spi_shift;    // Link side shift register
    logic                  lrst_m;       // Link reset sync stage 1
    logic                  lrst_q;       // Link reset, active low
    logic                  lshd_m;       // Link shutdown sync 1
    logic                  lshd_q;       // Link shutdown, active low
    logic [2:0]            cs_s;         // Chip select sync + history
    logic [2:0]            scl_s;        // Clock sync + history
    logic [2:0]            sda_s;        // Data sync + history
    logic [1:0]            isel_s;       // Interface select sync
    logic [1:0]            shd_s;        // Shutdown pin sync
    logic [1:0]            wrst_s;       // Wiper reset pin sync
    logic [1:0]            adlo_s;       // Address pin lo sync
    logic [1:0]            adhi_s;       // Address pin hi sync
    logic                  spi_load;     // Select rose in shift mode
    logic                  scl_rise;     // Clock rising, sampled
    logic                  scl_fall;     // Clock falling, sampled
    logic                  bus_start;    // Start seen
    logic                  bus_stop;     // Stop seen
    logic                  i2c_on;       // Slave mode engaged
    qps_pkg::qps_state_t   state;        // Slave sequencer state
    logic [3:0]            bit_cnt;      // Clock rises within byte
    logic [7:0]            rx_byte;      // Received byte
    logic [7:0]            tx_byte;      // Remaining bits to send
    logic                  master_ack;   // Master acked last byte
    logic [1:0]            cur_sel;      // Latest selected channel
    logic [3:0]            ch_shut;      // Per channel shutdown bits
    logic [3:0][7:0]       wiper;        // Wiper code latches
    logic                  instr_take;   // Instruction byte complete
    logic                  data_take;    // Data byte complete
    logic                  addr_match;   // Address byte is ours
    qps_pkg::qps_instr_t   instr;        // Received byte as fields
    qps_pkg::qps_spi_word_t spi_word;    // Shift word as fields

    assign instr    = qps_pkg::qps_instr_t'(rx_byte);
    assign spi_word = qps_pkg::qps_spi_word_t'(spi_shift);

    // ==============================================================
    // Link domain: shift port
    // Reset and shutdown reach the link clock through two flops
    always_ff @(posedge spi_clk_i) begin
        lrst_m <= rst_n_i;
        lrst_q <= lrst_m;
        lshd_m <= global_shutdown_pin_n_i;
        lshd_q <= lshd_m;
    end

    // Shift in on every rising edge while selected; MSB first
    always_ff @(posedge spi_clk_i) begin
        if (!lrst_q) begin
            spi_shift <= 10'h000;
        end else if (!spi_cs_n_i) begin
            // Older bits fall off the top, so the last ten stay
            spi_shift <= {spi_shift[8:0], spi_sdi_i};
        end
    end

    // Open-drain output changes on the falling edge. The forced
    // release under shutdown needs the link clock to run; with the
    // clock stopped the last level holds until the next edge.
    always_ff @(negedge spi_clk_i) begin
        if (!lrst_q) begin
            spi_sdo_oe_o <= 1'b0;
        end else begin
            spi_sdo_oe_o <= ~spi_shift[9] & lshd_q;
        end
    end

    // Open-drain: only ever pulls low
    always_ff @(negedge spi_clk_i) begin
        spi_sdo_o <= 1'b0;
    end

    // ==============================================================
    // Reference domain: pin synchronisers
    // First stages feed only their second stages
    always_ff @(posedge ref_clk_i) begin
        cs_s   <= {cs_s[1:0], spi_cs_n_i};
        scl_s  <= {scl_s[1:0], scl_i};
        sda_s  <= {sda_s[1:0], sda_i};
        isel_s <= {isel_s[0], interface_select_pin_i};
        shd_s  <= {shd_s[0], global_shutdown_pin_n_i};
        wrst_s <= {wrst_s[0], wiper_reset_pin_n_i};
        adlo_s <= {adlo_s[0], bus_address_pin_lo_i};
        adhi_s <= {adhi_s[0], bus_address_pin_hi_i};
    end

    // Edges from second and third stages only
    assign i2c_on    = isel_s[1];
    // Shift word is static once select is high, so it is safe to
    // read across domains after the two flop delay
    assign spi_load  = cs_s[1] & ~cs_s[2] & ~i2c_on;
    assign scl_rise  = scl_s[1] & ~scl_s[2];
    assign scl_fall  = ~scl_s[1] & scl_s[2];
    assign bus_start = i2c_on & scl_s[1] & scl_s[2]
                       & ~sda_s[1] & sda_s[2];
    assign bus_stop  = i2c_on & scl_s[1] & scl_s[2]
                       & sda_s[1] & ~sda_s[2];
    assign addr_match = (rx_byte[7:3] == ADDR_PREFIX)
                        && (rx_byte[2] == adhi_s[1])
                        && (rx_byte[1] == adlo_s[1]);
    assign instr_take = scl_fall && (state == qps_pkg::QPS_INSTR)
                        && (bit_cnt == `QPS_BITS_PER_BYTE);
    assign data_take  = scl_fall && (state == qps_pkg::QPS_DATA)
                        && (bit_cnt == `QPS_BITS_PER_BYTE);

    // ==============================================================
    // Two-wire slave sequencer
    // Start restarts from any state; stop always returns to idle
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i || !i2c_on) begin
            state    <= qps_pkg::QPS_IDLE;
            sda_oe_o <= 1'b0;
            bit_cnt  <= 4'h0;
        end else if (bus_start) begin
            state    <= qps_pkg::QPS_ADDR;
            sda_oe_o <= 1'b0;
            bit_cnt  <= 4'h0;
        end else if (bus_stop) begin
            state    <= qps_pkg::QPS_IDLE;
            sda_oe_o <= 1'b0;
        end else if (scl_rise) begin
            // Count clock pulses of the byte in flight
            if (state != qps_pkg::QPS_IDLE) begin
                bit_cnt <= bit_cnt + 4'h1;
            end
        end else if (scl_fall) begin
            case (state)
                qps_pkg::QPS_ADDR: begin
                    if (bit_cnt == `QPS_BITS_PER_BYTE) begin
                        if (addr_match) begin
                            sda_oe_o <= 1'b1;
                            state    <= qps_pkg::QPS_ADDR_ACK;
                        end else begin
                            // Not ours: stay off the bus
                            state    <= qps_pkg::QPS_IDLE;
                        end
                    end
                end
                qps_pkg::QPS_ADDR_ACK: begin
                    bit_cnt <= 4'h0;
                    if (rx_byte[0]) begin
                        // First data bit right after the acknowledge
                        sda_oe_o <= ~wiper[cur_sel][7];
                        state    <= qps_pkg::QPS_READ;
                    end else begin
                        sda_oe_o <= 1'b0;
                        state    <= qps_pkg::QPS_INSTR;
                    end
                end
                qps_pkg::QPS_INSTR: begin
                    if (bit_cnt == `QPS_BITS_PER_BYTE) begin
                        sda_oe_o <= 1'b1;
                        state    <= qps_pkg::QPS_INSTR_ACK;
                    end
                end
                qps_pkg::QPS_INSTR_ACK: begin
                    sda_oe_o <= 1'b0;
                    bit_cnt  <= 4'h0;
                    state    <= qps_pkg::QPS_DATA;
                end
                qps_pkg::QPS_DATA: begin
                    if (bit_cnt == `QPS_BITS_PER_BYTE) begin
                        sda_oe_o <= 1'b1;
                        state    <= qps_pkg::QPS_DATA_ACK;
                    end
                end
                qps_pkg::QPS_DATA_ACK: begin
                    sda_oe_o <= 1'b0;
                    bit_cnt  <= 4'h0;
                    state    <= qps_pkg::QPS_DATA;
                end
                qps_pkg::QPS_READ: begin
                    if (bit_cnt == `QPS_BITS_PER_BYTE) begin
                        // Let go for the master's acknowledge slot
                        sda_oe_o <= 1'b0;
                        state    <= qps_pkg::QPS_READ_ACK;
                    end else begin
                        sda_oe_o <= ~tx_byte[7];
                    end
                end
                qps_pkg::QPS_READ_ACK: begin
                    bit_cnt <= 4'h0;
                    if (master_ack) begin
                        sda_oe_o <= ~wiper[cur_sel][7];
                        state    <= qps_pkg::QPS_READ;
                    end else begin
                        // Nack: wait quietly for the stop
                        state    <= qps_pkg::QPS_IDLE;
                    end
                end
                default: begin
                    state <= qps_pkg::QPS_IDLE;
                end
            endcase
        end
    end

    // Received bits, MSB first, sampled on the rising clock
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            rx_byte <= 8'h00;
        end else if (scl_rise && (bit_cnt < `QPS_BITS_PER_BYTE)) begin
            rx_byte <= {rx_byte[6:0], sda_s[1]};
        end
    end

    // Master acknowledge sampled in the ninth read pulse
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            master_ack <= 1'b0;
        end else if (scl_rise && (state == qps_pkg::QPS_READ_ACK)) begin
            master_ack <= ~sda_s[1];
        end
    end

    // Transmit shifter; the MSB was already driven when loaded
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            tx_byte <= 8'h00;
        end else if (scl_fall && ((state == qps_pkg::QPS_ADDR_ACK)
                     || (state == qps_pkg::QPS_READ_ACK))) begin
            tx_byte <= {wiper[cur_sel][6:0], 1'b0};
        end else if (scl_fall && (state == qps_pkg::QPS_READ)) begin
            tx_byte <= {tx_byte[6:0], 1'b0};
        end
    end

    // Data line only ever pulled low
    always_ff @(posedge ref_clk_i) begin
        sda_o <= 1'b0;
    end

    // ==============================================================
    // Instruction effects: selection and logic outputs
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            cur_sel            <= 2'h0;
            logic_output_one_o <= `QPS_LOGIC_OUT_RST;
            logic_output_two_o <= `QPS_LOGIC_OUT_RST;
        end else if (instr_take) begin
            cur_sel            <= instr.chan_sel;
            logic_output_one_o <= instr.logic_output_one;
            logic_output_two_o <= instr.logic_output_two;
        end
    end

    // ==============================================================
    // Per channel latches, shutdown bits and shutdown output
    genvar ch;
    generate
        for (ch = 0; ch < `QPS_CHANNELS; ch++) begin : g_ch
            // Latch: reset pin wins, then either port's write
            always_ff @(posedge ref_clk_i) begin
                if (!rst_n_i || !wrst_s[1]) begin
                    wiper[ch] <= `QPS_MIDSCALE;
                end else if (spi_load
                             && (spi_word.chan_sel == 2'(ch))) begin
                    wiper[ch] <= spi_word.code;
                end else if (instr_take
                             && (instr.chan_sel == 2'(ch))
                             && instr.midscale_reset_bit) begin
                    wiper[ch] <= `QPS_MIDSCALE;
                end else if (data_take && (cur_sel == 2'(ch))) begin
                    wiper[ch] <= rx_byte;
                end
            end

            // Shutdown bit set or cleared only for its channel
            always_ff @(posedge ref_clk_i) begin
                if (!rst_n_i) begin
                    ch_shut[ch] <= 1'b0;
                end else if (instr_take
                             && (instr.chan_sel == 2'(ch))) begin
                    ch_shut[ch] <= instr.channel_shutdown_bit;
                end
            end

            // Latch contents untouched by either shutdown
            always_ff @(posedge ref_clk_i) begin
                if (!rst_n_i) begin
                    channel_off_o[ch]      <= 1'b0;
                    wiper_code_latch_o[ch] <= `QPS_MIDSCALE;
                end else begin
                    channel_off_o[ch]      <= ch_shut[ch]
                                              | ~shd_s[1];
                    wiper_code_latch_o[ch] <= wiper[ch];
                end
            end
        end
    endgenerate

endmodule

// File: shared/qps_defines.svh
// Constants of the quad potentiometer serial front end.
// Assumes inclusion by bare name from design and bench files.
`ifndef QPS_DEFINES_SVH
`define QPS_DEFINES_SVH

// ==================================================================
// Codes and reset values
`define QPS_MIDSCALE       8'h80
`define QPS_CODE_W         8
`define QPS_CHANNELS       4
`define QPS_SPI_WORD_W     10
`define QPS_LOGIC_OUT_RST  1'b0

// ==================================================================
// Instruction byte field positions
`define QPS_INS_SEL_HI     6
`define QPS_INS_SEL_LO     5
`define QPS_INS_MIDSCALE   4
`define QPS_INS_SHUTDOWN   3
`define QPS_INS_OUT_ONE    2
`define QPS_INS_OUT_TWO    1

// ==================================================================
// Bus framing
`define QPS_BITS_PER_BYTE  4'h8

`endif

// File: shared/qps_pkg.sv
// Types shared by the quad potentiometer serial front end.
// Assumes qps_defines.svh is on the include path.
`include "qps_defines.svh"

package qps_pkg;

    // ==============================================================
    // Two-wire slave sequencer states
    typedef enum logic [3:0] {
        QPS_IDLE      = 4'h0, // Waiting for a start
        QPS_ADDR      = 4'h1, // Receiving slave address byte
        QPS_ADDR_ACK  = 4'h2, // Driving address acknowledge
        QPS_INSTR     = 4'h3, // Receiving instruction byte
        QPS_INSTR_ACK = 4'h4, // Driving instruction acknowledge
        QPS_DATA      = 4'h5, // Receiving wiper code byte
        QPS_DATA_ACK  = 4'h6, // Driving data acknowledge
        QPS_READ      = 4'h7, // Sending wiper code byte
        QPS_READ_ACK  = 4'h8  // Sampling master acknowledge
    } qps_state_t;

    // Instruction byte, most significant bit first
    typedef struct packed {
        logic       ignore_hi;          // Don't care
        logic [1:0] chan_sel;           // Channel select hi, lo
        logic       midscale_reset_bit; // Force channel to midscale
        logic       channel_shutdown_bit; // Channel shutdown
        logic       logic_output_one;   // Logic output one level
        logic       logic_output_two;   // Logic output two level
        logic       ignore_lo;          // Don't care
    } qps_instr_t;

    // Three-wire shift word
    typedef struct packed {
        logic [1:0] chan_sel;           // Channel select hi, lo
        logic [7:0] code;               // Wiper code
    } qps_spi_word_t;

endpackage

// File: test/qps_host_model.sv
// Host model: three-wire shifter and two-wire bus master.
// Assumes pull-ups on SDO and SDA; two-wire timing on ref_clk_i.
`timescale 1ns/1ns
// ==================================================================
// Host
module qps_host_model (
    input  wire logic ref_clk_i,
    input  wire logic sdo_oe_i,
    input  wire logic sda_oe_i,
    output logic      spi_clk_o,
    output logic      spi_cs_n_o,
    output logic      spi_sdi_o,
    output logic      scl_o,
    output logic      sda_o
);
    logic        m_low;   // Master pulls SDA
    logic [19:0] sdo_cap; // Chain output seen at rising edges
    assign sda_o = !(m_low | sda_oe_i);
    initial begin
        spi_clk_o  = 1'b0;
        spi_cs_n_o = 1'b1;
        spi_sdi_o  = 1'b0;
        scl_o      = 1'b1;
        m_low      = 1'b0;
        sdo_cap    = 20'h0;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    // Link clock pulses, 6 ns period
    task automatic tick(input int n);
        repeat (n) begin
            #3 spi_clk_o = 1'b1;
            #3 spi_clk_o = 1'b0;
        end
    endtask
    // Frame of n bits, MSB first; chain output sampled on rises
    task automatic spi_frame(input logic [19:0] w, input int n);
        spi_cs_n_o = 1'b0;
        for (int k = n - 1; k >= 0; k--) begin
            spi_sdi_o = w[k];
            #3 spi_clk_o = 1'b1;
            sdo_cap = {sdo_cap[18:0], !sdo_oe_i};
            #3 spi_clk_o = 1'b0;
        end
        #3 spi_cs_n_o = 1'b1;
        // Released line shows the inverse, not a stale value
        spi_sdi_o = !spi_sdi_o;
        #40;
    endtask
    task automatic start();
        m_low = 1'b0;
        scl_o = 1'b1;
        wt(6);
        m_low = 1'b1;
        wt(6);
        scl_o = 1'b0;
    endtask
    task automatic stop();
        m_low = 1'b1;
        wt(6);
        scl_o = 1'b1;
        wt(6);
        m_low = 1'b0;
        wt(6);
    endtask
    // Nine clocks; tx[0] is the master's level in the ninth
    task automatic byte_x(input logic [8:0] tx, output logic [8:0] rx);
        for (int k = 8; k >= 0; k--) begin
            m_low = !tx[k];
            wt(6);
            scl_o = 1'b1;
            wt(3);
            rx[k] = sda_o;
            wt(3);
            scl_o = 1'b0;
        end
    endtask
endmodule

// File: test/qps_serial_front_chk.sv
// Port checker of the serial front end, bound after the module.
// Assumes rst_n_i resets both the reference and the link domain.
`timescale 1ns/1ns
`include "qps_defines.svh"
// ==================================================================
// Checker
module qps_serial_front_chk (
    input wire logic            ref_clk_i,
    input wire logic            rst_n_i,
    input wire logic            interface_select_pin_i,
    input wire logic            global_shutdown_pin_n_i,
    input wire logic            wiper_reset_pin_n_i,
    input wire logic            spi_clk_i,
    input wire logic            spi_sdo_o,
    input wire logic            spi_sdo_oe_o,
    input wire logic            scl_i,
    input wire logic            sda_o,
    input wire logic            sda_oe_o,
    input wire logic [3:0][7:0] wiper_code_latch_o,
    input wire logic [3:0]      channel_off_o,
    input wire logic            logic_output_one_o,
    input wire logic            logic_output_two_o
);
    // Data pins may only pull low
    a_drain_pulls_low: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !spi_sdo_o && !sda_o) else $error("open drain data high");
    // Leaving reset shows the power-on values
    a_reset_values: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i) $rose(rst_n_i) |->
        wiper_code_latch_o == {4{`QPS_MIDSCALE}} && channel_off_o == 4'h0
        && !logic_output_one_o && !logic_output_two_o)
        else $error("bad values after reset");
    // Margin of seven cycles covers the pin synchroniser
    a_reset_pin_mid: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !wiper_reset_pin_n_i [*7] |->
        wiper_code_latch_o == {4{`QPS_MIDSCALE}})
        else $error("reset pin left a wiper off midscale");
    a_pin_all_off: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !global_shutdown_pin_n_i [*7] |-> channel_off_o == 4'hF)
        else $error("shutdown pin missed a channel");
    // Shift mode keeps the two-wire side silent
    a_slave_quiet: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !interface_select_pin_i [*4] |-> !sda_oe_o)
        else $error("SDA driven in shift mode");
    a_outs_hold: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !interface_select_pin_i [*4] |->
        $stable({logic_output_one_o, logic_output_two_o}))
        else $error("logic outputs moved in shift mode");
    // SDA may only move while SCL is low, else a false start or stop
    a_ack_scl_low: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        $changed(sda_oe_o) |-> !scl_i)
        else $error("SDA changed while SCL high");
    // Link flop needs a few link edges to release SDO
    a_sdo_release: assert property (
        @(negedge spi_clk_i) disable iff (!rst_n_i)
        !global_shutdown_pin_n_i [*4] |-> !spi_sdo_oe_o)
        else $error("SDO pulled low in shutdown");
endmodule
bind qps_serial_front qps_serial_front_chk i_chk (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
    .interface_select_pin_i(interface_select_pin_i),
    .global_shutdown_pin_n_i(global_shutdown_pin_n_i),
    .wiper_reset_pin_n_i(wiper_reset_pin_n_i), .spi_clk_i(spi_clk_i),
    .spi_sdo_o(spi_sdo_o), .spi_sdo_oe_o(spi_sdo_oe_o), .scl_i(scl_i),
    .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .wiper_code_latch_o(wiper_code_latch_o),
    .channel_off_o(channel_off_o),
    .logic_output_one_o(logic_output_one_o),
    .logic_output_two_o(logic_output_two_o));

// File: test/tb.sv
// Testbench of the serial front end: shift frames, then bus transfers.
// Assumes the host model and the bound checker are compiled first.
`timescale 1ns/1ns
// ==================================================================
// Bench
module tb;
    localparam logic [4:0] PFX = 5'h15; // Arbitrary bus prefix
    logic ref_clk, rst_n, sel, global_shutdown_pin_n, wrst_n, a_lo, a_hi;
    logic spi_clk, cs_n, sdi, sdo, sdo_oe, scl, sda, sda_d, sda_oe;
    logic [3:0][7:0] latch;
    logic [3:0]      off;
    logic            o1, o2;
    logic [8:0]      rx;
    int failures, comparisons, cycles;
    qps_serial_front #(.ADDR_PREFIX(PFX)) i_dut (
        .ref_clk_i(ref_clk), .rst_n_i(rst_n),
        .interface_select_pin_i(sel), .global_shutdown_pin_n_i(global_shutdown_pin_n),
        .wiper_reset_pin_n_i(wrst_n), .spi_clk_i(spi_clk),
        .spi_cs_n_i(cs_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo),
        .spi_sdo_oe_o(sdo_oe), .scl_i(scl), .sda_i(sda), .sda_o(sda_d),
        .sda_oe_o(sda_oe), .bus_address_pin_lo_i(a_lo),
        .bus_address_pin_hi_i(a_hi), .wiper_code_latch_o(latch),
        .channel_off_o(off), .logic_output_one_o(o1),
        .logic_output_two_o(o2));
    qps_host_model m (.ref_clk_i(ref_clk), .sdo_oe_i(sdo_oe),
        .sda_oe_i(sda_oe), .spi_clk_o(spi_clk), .spi_cs_n_o(cs_n),
        .spi_sdi_o(sdi), .scl_o(scl), .sda_o(sda));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = !ref_clk;
    end
    // Hang guard, well above the expected run
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failures++;
            conclude();
        end
    end
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    function automatic logic [7:0] adr(input logic rw);
        return {PFX, a_hi, a_lo, rw};
    endfunction
    // Write: instruction, then nd codes d, d+1, ...
    task automatic i2c_wr(input logic [7:0] ins, d, input int nd);
        m.start();
        m.byte_x({adr(1'b0), 1'b1}, rx);
        chk(rx[0], 1'b0);
        m.byte_x({ins, 1'b1}, rx);
        chk(rx[0], 1'b0);
        for (int k = 0; k < nd; k++) begin
            m.byte_x({d + k[7:0], 1'b1}, rx);
            chk(rx[0], 1'b0);
        end
        m.stop();
        m.wt(4);
    endtask
    initial begin
        {rst_n, sel, a_hi, failures, comparisons, cycles} = '0;
        {global_shutdown_pin_n, wrst_n, a_lo} = 3'h7;
        m.tick(4);
        m.wt(8);
        rst_n = 1'b1;
        // Link side leaves reset only on its own clock edges
        m.tick(4);
        m.wt(4);
        chk(latch, 32'h80808080);
        chk({o1, o2}, 2'h0);
        // Every select code, then a chained twenty-bit frame
        for (int c = 0; c < 4; c++) begin
            m.spi_frame({10'h0, c[1:0], 8'h10 + c[7:0]}, 10);
            m.wt(8);
            chk(latch[c], 8'h10 + c[7:0]);
        end
        m.spi_frame({10'h0A5, 10'h35A}, 20);
        m.wt(8);
        chk(m.sdo_cap, {10'h313, 10'h0A5});
        chk(latch, 32'h5A121110);
        // Shutdown pin: SDO released, all off, loads still taken
        global_shutdown_pin_n = 1'b0;
        m.wt(8);
        m.tick(4);
        m.spi_frame(20'h0, 10);
        m.wt(8);
        chk(m.sdo_cap[9:0], 10'h3FF);
        chk(off, 4'hF);
        chk(latch, 32'h5A121100);
        global_shutdown_pin_n = 1'b1;
        m.wt(8);
        chk(off, 4'h0);
        wrst_n = 1'b0;
        m.wt(10);
        wrst_n = 1'b1;
        m.wt(6);
        chk(latch, 32'h80808080);
        sel = 1'b1;
        m.wt(6);
        i2c_wr(8'h44, 8'h77, 2);
        chk({latch, o1, o2}, {32'h80788080, 2'h2});
        // Foreign address stays unanswered
        m.start();
        m.byte_x({adr(1'b0) ^ 8'h02, 1'b1}, rx);
        chk(rx[0], 1'b1);
        m.stop();
        // Move both address pins; later transfers use the new address
        {a_hi, a_lo} = 2'h2;
        m.wt(4);
        i2c_wr(8'h48, 8'h00, 0);
        chk({latch, off, o1}, {32'h80788080, 4'h4, 1'b0});
        m.start();
        m.byte_x({adr(1'b1), 1'b1}, rx);
        chk(rx[0], 1'b0);
        m.byte_x({8'hFF, 1'b0}, rx);
        chk(rx[8:1], 8'h78);
        m.byte_x({8'hFF, 1'b1}, rx);
        chk(rx[8:1], 8'h78);
        m.stop();
        i2c_wr(8'h52, 8'h00, 0);
        chk({latch, off, o2}, {32'h80808080, 4'h0, 1'b1});
        // Shift frames are ignored in slave mode
        m.spi_frame(20'h3FF, 10);
        m.wt(8);
        chk(latch, 32'h80808080);
        conclude();
    end
endmodule
